// file: logic/adchi_host.sv
`timescale 1ns/1ps
`include "adchi_params.svh"
module adchi_host
  import adchi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq,
  // pins toward the converter
  adchi_if.host link
);
  localparam int W = `ADCHI_WIDTH;
  localparam int V = `ADCHI_VEC;
  localparam logic [7:0] HALF = 8'(`ADCHI_CYC(`ADCHI_SCLK_HALF_NS));
  localparam logic [7:0] STB = 8'(`ADCHI_CYC(`ADCHI_STROBE_NS));
  localparam logic [7:0] CPUL = 8'(`ADCHI_CYC(`ADCHI_CONV_PULSE_NS));

  function automatic logic adchi_mapped(input logic [7:0] a);
    adchi_mapped = (a <= `ADCHI_A_ICLR) || (a >= `ADCHI_A_DATA && a < 8'(`ADCHI_A_DATA + 4 * `ADCHI_NCH));
  endfunction : adchi_mapped

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [16:0] s1;
  logic [16:0] s2;
  logic busy_s;
  logic [15:0] bus_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 17'h0_0000;
      s2 <= 17'h0_0000;
    end else begin
      s1 <= {link.busy, link.bus};
      s2 <= s1;
    end
  end
  assign busy_s = s2[16];
  assign bus_s = s2[15:0];

  // ----------------------------------------------------------------
  // axi write side
  // ----------------------------------------------------------------
  logic aw_full;
  logic w_full;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCHI_RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= adchi_mapped(awaddr_q) ? `ADCHI_RESP_OK : `ADCHI_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control, status and interrupt registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [`ADCHI_NEV-1:0] stat;
  logic [`ADCHI_NEV-1:0] ien;
  logic [`ADCHI_NEV-1:0] ev;
  logic [`ADCHI_NEV-1:0] clr;
  adchi_hstate_t st;
  logic cmd_go;

  assign clr = (wr_go && awaddr_q == `ADCHI_A_ICLR) ? wdata_q[`ADCHI_NEV-1:0] : '0;
  assign cmd_go = wr_go && awaddr_q == `ADCHI_A_CMD && st == H_IDLE;
  assign irq = |(stat & ien);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `ADCHI_CTRL_RST;
      ien <= '0;
    end else if (wr_go) begin
      if (awaddr_q == `ADCHI_A_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) begin
            ctrl[8*b +: 8] <= wdata_q[8*b +: 8];
          end
        end
      end
      if (awaddr_q == `ADCHI_A_IEN) begin
        ien <= wdata_q[`ADCHI_NEV-1:0];
      end
    end
  end

  // a new event outranks a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~clr) | ev;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  logic [7:0] cnt;
  logic [6:0] idx;
  logic seen;
  logic [V-1:0] rvec;
  logic [V-1:0] cap_a;
  logic [V/2-1:0] cap_b;
  logic [V/2-1:0] cap_c;
  logic [V-1:0] next_a;
  logic [V/2-1:0] next_b;
  logic [V/2-1:0] next_c;
  logic cs_q;
  logic rd_q;
  logic wr_q;
  logic sclk_q;
  logic drive_q;
  adchi_lanes_t lanes;
  logic [6:0] frame_len;

  assign lanes = adchi_lanes(ctrl[`ADCHI_C_LANE_B], ctrl[`ADCHI_C_LANE_C]);
  assign frame_len = 7'(V / 32'(lanes));
  assign next_a = {cap_a[V-2:0], bus_s[`ADCHI_OUT_A]};
  assign next_b = {cap_b[V/2-2:0], bus_s[`ADCHI_OUT_B]};
  assign next_c = {cap_c[V/2-2:0], bus_s[`ADCHI_OUT_C]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= H_IDLE;
      cnt <= 8'h00;
      idx <= 7'h00;
      seen <= 1'b0;
      rvec <= '0;
      cap_a <= '0;
      cap_b <= '0;
      cap_c <= '0;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      sclk_q <= 1'b1;
      drive_q <= 1'b0;
      link.conv_start <= 1'b0;
      ev <= '0;
    end else begin
      ev <= '0;
      case (st)
        H_IDLE: begin
          idx <= 7'h00;
          cnt <= STB;
          if (cmd_go && wdata_q[`ADCHI_K_START] && !busy_s) begin
            st <= H_CONV;
            link.conv_start <= 1'b1;
            cnt <= CPUL;
            seen <= 1'b0;
          end else if (cmd_go && wdata_q[`ADCHI_K_READ]) begin
            cs_q <= 1'b0;
            if (ctrl[`ADCHI_C_SER]) begin
              st <= H_SER;
              cnt <= HALF;
            end else begin
              st <= H_PRD;
              rd_q <= 1'b0;
            end
          end else if (cmd_go && wdata_q[`ADCHI_K_WRITE] && ctrl[`ADCHI_C_SW] && !ctrl[`ADCHI_C_SER]) begin
            st <= H_PWR;
            cs_q <= 1'b0;
            wr_q <= 1'b0;
            drive_q <= 1'b1;
          end
        end
        H_CONV: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            link.conv_start <= 1'b0;
          end
          if (busy_s) begin
            seen <= 1'b1;
          end
          if (seen && !busy_s && !link.conv_start) begin
            ev[`ADCHI_K_START] <= 1'b1;
            st <= H_IDLE;
          end
        end
        H_PRD: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (!cs_q) begin
            rvec[V-1-W*32'(idx) -: W] <= bus_s;
            cs_q <= 1'b1;
            rd_q <= 1'b1;
            cnt <= STB;
            idx <= idx + 7'h01;
          end else if (idx == 7'(`ADCHI_NCH)) begin
            ev[`ADCHI_K_READ] <= 1'b1;
            st <= H_IDLE;
          end else begin
            cs_q <= 1'b0;
            rd_q <= 1'b0;
            cnt <= STB;
          end
        end
        H_PWR: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            cs_q <= 1'b1;
            wr_q <= 1'b1;
            drive_q <= 1'b0;
            ev[`ADCHI_K_WRITE] <= 1'b1;
            st <= H_IDLE;
          end
        end
        H_SER: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (sclk_q) begin
            cnt <= HALF;
            cap_a <= next_a;
            cap_b <= next_b;
            cap_c <= next_c;
            if (idx == frame_len - 7'h01) begin
              cs_q <= 1'b1;
              ev[`ADCHI_K_READ] <= 1'b1;
              st <= H_IDLE;
              case (lanes)
                2'h2: rvec <= {next_a[V/2-1:0], next_b};
                2'h3: rvec <= {next_a[2*W-1:0], next_b[2*W-1:0], next_c[2*W-1:0]};
                default: rvec <= next_a;
              endcase
            end else begin
              sclk_q <= 1'b0;
            end
          end else begin
            cnt <= HALF;
            sclk_q <= 1'b1;
            idx <= idx + 7'h01;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  assign link.cs_n = cs_q;
  assign link.rd_n = ctrl[`ADCHI_C_SER] ? 1'b0 : rd_q;
  assign link.wr_n = ctrl[`ADCHI_C_SW] ? wr_q : ctrl[`ADCHI_C_REF];
  assign link.hs_mode = ctrl[`ADCHI_C_SW];
  assign link.choice = ctrl[`ADCHI_C_SER];

  always_comb begin
    link.host_o = 16'h0000;
    link.host_oe = 16'h0000;
    if (ctrl[`ADCHI_C_SER]) begin
      // grounded pins are driven low: 15, 13..11, and chain inputs when unchained
      link.host_oe = 16'hB8C7;
      link.host_o[`ADCHI_SEL_A] = 1'b1;
      link.host_o[`ADCHI_SEL_B] = ctrl[`ADCHI_C_LANE_B];
      link.host_o[`ADCHI_SEL_C] = ctrl[`ADCHI_C_LANE_C];
      link.host_o[`ADCHI_SCLK] = sclk_q;
      link.host_o[`ADCHI_CHAIN_EN] = ctrl[`ADCHI_C_CHAIN];
      link.host_oe[`ADCHI_CHAIN_A] = !ctrl[`ADCHI_C_CHAIN];
      link.host_oe[`ADCHI_CHAIN_B] = !ctrl[`ADCHI_C_CHAIN];
      link.host_oe[`ADCHI_CHAIN_C] = !ctrl[`ADCHI_C_CHAIN];
    end else if (drive_q) begin
      link.host_o[15:8] = ctrl[`ADCHI_C_VAL +: 8];
      link.host_oe[15:8] = 8'hFF;
    end
  end

  // ----------------------------------------------------------------
  // axi read side
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [7:0] roff;

  assign s_axi_arready = !s_axi_rvalid;
  assign roff = s_axi_araddr - `ADCHI_A_DATA;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `ADCHI_A_CTRL: rd_mux = ctrl;
      `ADCHI_A_CMD: rd_mux = {30'h0000_0000, busy_s, st != H_IDLE};
      `ADCHI_A_STAT: rd_mux[`ADCHI_NEV-1:0] = stat;
      `ADCHI_A_IEN: rd_mux[`ADCHI_NEV-1:0] = ien;
      default: begin
        if (s_axi_araddr >= `ADCHI_A_DATA) begin
          rd_mux[W-1:0] = rvec[V-1-W*32'(roff[7:2]) -: W];
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ADCHI_RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= adchi_mapped(s_axi_araddr) ? rd_mux : 32'h0000_0000;
      s_axi_rresp <= adchi_mapped(s_axi_araddr) ? `ADCHI_RESP_OK : `ADCHI_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : adchi_host

// file: pkg/adchi_params.svh
`ifndef ADCHI_PARAMS_SVH
`define ADCHI_PARAMS_SVH
// Function
// - parallel read drives bus while select, read low
// - software mode write takes upper byte into control
// - serial frame by select low, MSB at fall
// - host holds read strobe low in serial mode
// - hardware mode store pin sets reference on/off
// - busy high from start until results latched
// - host never starts conversion while busy high
// - choice pin low parallel, high serial
// - serial mode remaps data pins to lanes, selects
// - host grounds pins 15 and 13..11 serially
// - parallel mode pins 0,1 are three-state outputs
// - lane A select enables A, host drives one
// - lane B select enables second serial output
// - lane C select enables third serial output
// - chain enable takes pins 5..3 as chain inputs
// - pin 6 is host serial clock in serial

// ----------------------------------------------------------------
// sizes and pin positions
// ----------------------------------------------------------------
`define ADCHI_WIDTH 16
`define ADCHI_NCH 6
`define ADCHI_VEC (`ADCHI_NCH * `ADCHI_WIDTH)
`define ADCHI_SEL_A 0
`define ADCHI_SEL_B 1
`define ADCHI_SEL_C 2
`define ADCHI_CHAIN_C 3
`define ADCHI_CHAIN_B 4
`define ADCHI_CHAIN_A 5
`define ADCHI_SCLK 6
`define ADCHI_CHAIN_EN 7
`define ADCHI_OUT_A 8
`define ADCHI_OUT_B 9
`define ADCHI_OUT_C 10
`define ADCHI_SYNC_RST 22'h38_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCHI_CLK_MHZ 50
`define ADCHI_CYC(ns) (((ns) * `ADCHI_CLK_MHZ + 999) / 1000)
`define ADCHI_SCLK_HALF_NS 160
`define ADCHI_STROBE_NS 160
`define ADCHI_CONV_PULSE_NS 40

// ----------------------------------------------------------------
// host register map
// ----------------------------------------------------------------
`define ADCHI_A_CTRL 8'h00
`define ADCHI_A_CMD 8'h04
`define ADCHI_A_STAT 8'h08
`define ADCHI_A_IEN 8'h0C
`define ADCHI_A_ICLR 8'h10
`define ADCHI_A_DATA 8'h20
`define ADCHI_CTRL_RST 32'h0000_0000
`define ADCHI_C_SER 0
`define ADCHI_C_SW 1
`define ADCHI_C_REF 2
`define ADCHI_C_LANE_B 3
`define ADCHI_C_LANE_C 4
`define ADCHI_C_CHAIN 5
`define ADCHI_C_VAL 8
`define ADCHI_K_START 0
`define ADCHI_K_READ 1
`define ADCHI_K_WRITE 2
`define ADCHI_NEV 3
`define ADCHI_RESP_OK 2'h0
`define ADCHI_RESP_ERR 2'h2
`endif

// file: pkg/adchi_pkg.sv
`include "adchi_params.svh"
package adchi_pkg;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_CONV = 5'h02,
    H_PRD = 5'h04,
    H_PWR = 5'h08,
    H_SER = 5'h10
  } adchi_hstate_t;
  typedef logic [1:0] adchi_lanes_t;

  // lane count from the two upper select pins
  function automatic adchi_lanes_t adchi_lanes(input logic sel_b, input logic sel_c);
    adchi_lanes = sel_c ? 2'h3 : (sel_b ? 2'h2 : 2'h1);
  endfunction : adchi_lanes
endpackage : adchi_pkg

// file: pkg/adchi_if.sv
`timescale 1ns/1ps
interface adchi_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic hs_mode;
  logic choice;
  logic conv_start;
  logic busy;
  logic [15:0] dev_o;
  logic [15:0] dev_oe;
  logic [15:0] host_o;
  logic [15:0] host_oe;
  logic [15:0] bus;

  // undriven lines read low, like a grounded pin
  assign bus = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o);

  modport dev(input cs_n, rd_n, wr_n, hs_mode, choice, conv_start, bus, output busy, dev_o, dev_oe);
  modport host(output cs_n, rd_n, wr_n, hs_mode, choice, conv_start, host_o, host_oe, input busy, bus);
endinterface : adchi_if

// file: logic/adchi_device.sv
`timescale 1ns/1ps
`include "adchi_params.svh"
module adchi_device
  import adchi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins toward the host
  adchi_if.dev link,
  // converter core
  input wire logic conv_done,
  input wire logic [`ADCHI_VEC-1:0] result,
  output logic conv_begin,
  output logic [7:0] control_value,
  output logic internal_reference_on,
  output logic serial_mode
);
  localparam int W = `ADCHI_WIDTH;
  localparam int V = `ADCHI_VEC;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [21:0] pin_in;
  logic [21:0] s1;
  logic [21:0] s2;
  logic [21:0] sp;

  assign pin_in = {link.cs_n, link.rd_n, link.wr_n, link.hs_mode, link.choice, link.conv_start, link.bus};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= `ADCHI_SYNC_RST;
      s2 <= `ADCHI_SYNC_RST;
      sp <= `ADCHI_SYNC_RST;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      sp <= s2;
    end
  end

  logic cs_lo;
  logic rd_lo;
  logic wr_pin;
  logic sw_mode;
  logic ser;
  logic [15:0] parallel_bus_line;
  logic cs_fall;
  logic start_rise;
  logic sclk_fall;
  logic read_end;
  logic chain_enable_pin;
  adchi_lanes_t lanes;

  assign cs_lo = !s2[21];
  assign rd_lo = !s2[20];
  assign wr_pin = s2[19];
  assign sw_mode = s2[18];
  assign ser = s2[17];
  assign parallel_bus_line = s2[15:0];
  assign cs_fall = !s2[21] && sp[21];
  assign start_rise = s2[16] && !sp[16];
  assign sclk_fall = !parallel_bus_line[`ADCHI_SCLK] && sp[`ADCHI_SCLK];
  assign read_end = !sp[21] && !sp[20] && !(cs_lo && rd_lo);
  assign chain_enable_pin = parallel_bus_line[`ADCHI_CHAIN_EN];
  assign lanes = adchi_lanes(parallel_bus_line[`ADCHI_SEL_B], parallel_bus_line[`ADCHI_SEL_C]);
  assign serial_mode = ser;

  // ----------------------------------------------------------------
  // conversion busy and result latch
  // ----------------------------------------------------------------
  logic busy;
  logic [V-1:0] latched;

  // a start edge while busy is dropped; the host is not meant to send one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      conv_begin <= 1'b0;
      latched <= '0;
    end else begin
      conv_begin <= 1'b0;
      if (start_rise && !busy) begin
        busy <= 1'b1;
        conv_begin <= 1'b1;
      end else if (busy && conv_done) begin
        busy <= 1'b0;
        latched <= result;
      end
    end
  end

  assign link.busy = busy;

  // ----------------------------------------------------------------
  // parallel word pointer
  // ----------------------------------------------------------------
  logic [2:0] ptr;

  // each finished read moves to the next channel, wrapping after the last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= 3'h0;
    end else if (busy && conv_done) begin
      ptr <= 3'h0;
    end else if (!ser && read_end) begin
      ptr <= (ptr == 3'(`ADCHI_NCH - 1)) ? 3'h0 : ptr + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // control register and reference
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_value <= 8'h00;
    end else if (sw_mode && !ser && cs_lo && !wr_pin) begin
      control_value <= parallel_bus_line[15:8];
    end
  end

  // in software mode the pin is a write strobe, so the last level is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_reference_on <= 1'b0;
    end else if (!sw_mode) begin
      internal_reference_on <= wr_pin;
    end
  end

  // ----------------------------------------------------------------
  // serial shift registers
  // ----------------------------------------------------------------
  logic [V-1:0] sh_a;
  logic [V/2-1:0] sh_b;
  logic [V/2-1:0] sh_c;
  logic in_a;
  logic in_b;
  logic in_c;

  // chained parts feed their inputs into the tail of each lane
  assign in_a = chain_enable_pin && parallel_bus_line[`ADCHI_CHAIN_A];
  assign in_b = chain_enable_pin && parallel_bus_line[`ADCHI_CHAIN_B];
  assign in_c = chain_enable_pin && parallel_bus_line[`ADCHI_CHAIN_C];

  // one lane carries all six words, two lanes three each, three lanes two each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_a <= '0;
      sh_b <= '0;
      sh_c <= '0;
    end else if (ser && cs_fall) begin
      case (lanes)
        2'h2: begin
          sh_a <= {latched[V-1 -: V/2], {(V/2){1'b0}}};
          sh_b <= latched[V/2-1:0];
          sh_c <= '0;
        end
        2'h3: begin
          sh_a <= {latched[V-1 -: 2*W], {(V-2*W){1'b0}}};
          sh_b <= {latched[V-2*W-1 -: 2*W], {(V/2-2*W){1'b0}}};
          sh_c <= {latched[2*W-1:0], {(V/2-2*W){1'b0}}};
        end
        default: begin
          sh_a <= latched;
          sh_b <= '0;
          sh_c <= '0;
        end
      endcase
    end else if (ser && cs_lo && sclk_fall) begin
      sh_a <= {sh_a[V-2:0], in_a};
      sh_b <= {sh_b[V/2-2:0], in_b};
      sh_c <= {sh_c[V/2-2:0], in_c};
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [15:0] next_o;
  logic [15:0] next_oe;

  always_comb begin
    next_o = 16'h0000;
    next_oe = 16'h0000;
    if (!ser) begin
      next_o = latched[V-1-W*32'(ptr) -: W];
      // all lines float unless both strobes are low
      if (cs_lo && rd_lo) begin
        next_oe = 16'hFFFF;
      end
    end else begin
      next_o[`ADCHI_OUT_A] = sh_a[V-1];
      next_o[`ADCHI_OUT_B] = sh_b[V/2-1];
      next_o[`ADCHI_OUT_C] = sh_c[V/2-1];
      next_oe[`ADCHI_OUT_A] = parallel_bus_line[`ADCHI_SEL_A];
      next_oe[`ADCHI_OUT_B] = parallel_bus_line[`ADCHI_SEL_A] && parallel_bus_line[`ADCHI_SEL_B];
      next_oe[`ADCHI_OUT_C] = parallel_bus_line[`ADCHI_SEL_A] && parallel_bus_line[`ADCHI_SEL_C];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dev_o <= 16'h0000;
      link.dev_oe <= 16'h0000;
    end else begin
      link.dev_o <= next_o;
      link.dev_oe <= next_oe;
    end
  end
endmodule : adchi_device

// file: test/adchi_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link pin checks
// ----------------------------------------------------------------
module adchi_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic choice,
  input wire logic conv_start,
  input wire logic busy,
  input wire logic [15:0] dev_oe,
  input wire logic [15:0] bus
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_par_on; (!choice && !cs_n && !rd_n) [*5] |-> dev_oe == 16'hFFFF; endproperty
  a_par_on: assert property (p_par_on) else $error("bus not driven");
  // eight cycles leave room for the mode change to reach the device
  property p_par_off; (!choice && (cs_n || rd_n)) [*8] |-> dev_oe == 16'h0000; endproperty
  a_par_off: assert property (p_par_off) else $error("bus not released");
  property p_no_start; $rose(conv_start) |-> !busy; endproperty
  a_no_start: assert property (p_no_start) else $error("start while busy");
  property p_busy_rise; $rose(conv_start) |-> ##[1:8] busy; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy missing");
  property p_ser_rd; choice && $past(choice) |-> !rd_n; endproperty
  a_ser_rd: assert property (p_ser_rd) else $error("read strobe high");
  property p_sel_a; choice && $past(choice) |-> bus[0]; endproperty
  a_sel_a: assert property (p_sel_a) else $error("lane a select low");
  property p_gnd; choice && $past(choice) |-> !bus[15] && bus[13:11] == 3'h0; endproperty
  a_gnd: assert property (p_gnd) else $error("unused pins high");
  property p_lane_a; (choice && !cs_n) [*5] |-> dev_oe[8] && dev_oe[7:0] == 8'h00; endproperty
  a_lane_a: assert property (p_lane_a) else $error("lane a wrong");
  property p_lane_b; (choice && !cs_n && !bus[1]) [*5] |-> !dev_oe[9]; endproperty
  a_lane_b: assert property (p_lane_b) else $error("lane b driven");
  property p_lane_c; (choice && !cs_n && !bus[2]) [*5] |-> !dev_oe[10]; endproperty
  a_lane_c: assert property (p_lane_c) else $error("lane c driven");
endmodule : adchi_asserts

// file: test/test_adc_host_interface_control.sv
`timescale 1ns/1ps
module test_adc_host_interface_control;
  logic aclk, aresetn, conv_done, awv, wv, bre, arv, rre, awr, wr_rdy, bv, arr, rv, irq, ref_on, ser;
  logic [95:0] result = 96'h1111_2222_3333_4444_5555_6666;
  logic [7:0] awa, ara, cval;
  logic [31:0] wd, rdat, d;
  logic [1:0] br, rr, rs;
  logic [2:0] ien;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_begin = 0;
  logic cbeg;
  adchi_if lnk();
  adchi_device i_adchi_device(.aclk(aclk), .aresetn(aresetn), .link(lnk), .conv_done(conv_done),
    .result(result), .conv_begin(cbeg), .control_value(cval), .internal_reference_on(ref_on), .serial_mode(ser));
  adchi_host i_adchi_host(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .irq(irq), .link(lnk));
  adchi_asserts i_adchi_asserts(.aclk(aclk), .aresetn(aresetn), .cs_n(lnk.cs_n), .rd_n(lnk.rd_n),
    .choice(lnk.choice), .conv_start(lnk.conv_start), .busy(lnk.busy), .dev_oe(lnk.dev_oe), .bus(lnk.bus));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    rs = br;
    bre <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rre <= 1'b0;
    d = rdat;
    rs = rr;
  endtask : rd
  // issue a command, wait for its done flag, then check and clear the interrupt
  task op(input int c);
    int k;
    wr(8'h04, 32'h0000_0001 << c);
    k = 0;
    do begin
      rd(8'h08);
      k++;
    end while (d[c] !== 1'b1 && k < 3000);
    chk("stat", 32'h0000_0001 << c, d & (32'h0000_0001 << c));
    chk("irq", {31'h0, ien[c]}, {31'h0, irq});
    wr(8'h10, 32'h0000_0001 << c);
    @(posedge aclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : op
  task data_chk;
    for (int i = 0; i < 6; i++) begin
      rd(8'h20 + 8'(4 * i));
      chk("data", 32'(16'h1111 * (i + 1)), d);
    end
  endtask : data_chk
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // the core finishes one cycle after busy shows, so busy spans at least two cycles
  always_ff @(posedge aclk) conv_done <= lnk.busy;
  // every accepted start must reach the core exactly once
  always @(posedge aclk) begin
    if (cbeg === 1'b1) n_begin <= n_begin + 1;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {aresetn, awv, wv, bre, arv, rre} = 6'h00;
    {awa, ara, wd} = 48'h0000_0000_0000;
    ien = 3'h7;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    chk("ctrl", 32'h0000_0000, d);
    rd(8'h40);
    chk("resp", 32'h0000_0002, {30'h0, rs});
    wr(8'h40, 32'h0000_0000);
    chk("bresp", 32'h0000_0002, {30'h0, rs});
    wr(8'h00, 32'h0000_0004);
    repeat (8) @(posedge aclk);
    chk("ref", 32'h0000_0001, {31'h0, ref_on});
    wr(8'h00, 32'h0000_0000);
    repeat (8) @(posedge aclk);
    chk("ref", 32'h0000_0000, {31'h0, ref_on});
    wr(8'h0C, 32'h0000_0007);
    op(0);
    op(1);
    data_chk();
    wr(8'h00, 32'h0000_A502);
    op(2);
    chk("cval", 32'h0000_00A5, {24'h0, cval});
    ien = 3'h6;
    wr(8'h0C, 32'h0000_0006);
    // the last pass sets the chain pin with three lanes; idle chain inputs must leave the data intact
    for (int l = 0; l < 4; l++) begin
      wr(8'h00, {26'h0, l > 2, l > 1, l > 0, 3'h1});
      op(0);
      op(1);
      data_chk();
      chk("ser", 32'h0000_0001, {31'h0, ser});
    end
    chk("begins", 32'h0000_0005, n_begin);
    end_of_test();
  end
endmodule : test_adc_host_interface_control
